// ---- rtl/sspe_alu.sv ----
// combinational datapath: skips, fills, subtraction and nibble exchange
`timescale 1ns/1ps
`include "sspe_regs.svh"
module sspe_alu (
   sspe_alu_if.alu a   // operands in, results out
);
   import sspe_pkg::*;

   logic [7:0] inc_val;
   logic [7:0] dec_val;
   logic [7:0] sub_opnd;
   logic [8:0] diff;
   logic [4:0] half;

   // -----------------------------------------------------------------------------
   // arithmetic
   // -----------------------------------------------------------------------------
   assign inc_val  = a.mem + 8'h01;
   assign dec_val  = a.mem - 8'h01;
   assign sub_opnd = (a.op == OP_MINUS_IMM) ? a.imm : a.mem;
   assign diff     = {1'b0, a.acc} + {1'b0, ~sub_opnd} + 9'h001;
   assign half     = {1'b0, a.acc[3:0]} + {1'b0, ~sub_opnd[3:0]} + 5'h01;

   // -----------------------------------------------------------------------------
   // result selection
   // -----------------------------------------------------------------------------
   always_comb begin
      a.res_acc   = a.acc;
      a.res_mem   = a.mem;
      a.res_flags = a.flags;
      a.acc_we    = 1'b0;
      a.mem_we    = 1'b0;
      a.skip      = 1'b0;
      unique case (a.op)
         OP_DECR_TO_WORK_SKIP: begin
            a.res_acc = dec_val;
            a.acc_we  = 1'b1;
            a.skip    = (dec_val == 8'h00);
         end
         OP_FILL_BYTE: begin
            a.res_mem = 8'hff;
            a.mem_we  = 1'b1;
         end
         OP_FILL_BIT: begin
            a.res_mem = a.mem | (8'h01 << a.bit_sel);
            a.mem_we  = 1'b1;
         end
         OP_INCR_SKIP_MEM: begin
            a.res_mem = inc_val;
            a.mem_we  = 1'b1;
            a.skip    = (inc_val == 8'h00);
         end
         OP_INCR_TO_WORK_SKIP: begin
            a.res_acc = inc_val;
            a.acc_we  = 1'b1;
            a.skip    = (inc_val == 8'h00);
         end
         OP_SKIP_WHEN_BIT_HIGH: begin
            a.skip = a.mem[a.bit_sel];
         end
         OP_SKIP_WHEN_BIT_LOW: begin
            a.skip = ~a.mem[a.bit_sel];
         end
         OP_MINUS_TO_WORK, OP_MINUS_IMM, OP_MINUS_TO_MEMORY: begin
            // four arithmetic flags
            a.res_flags[`SSPE_FLAG_CARRY] = diff[8];
            a.res_flags[`SSPE_FLAG_HALF]  = half[4];
            a.res_flags[`SSPE_FLAG_ZERO]  = (diff[7:0] == 8'h00);
            a.res_flags[`SSPE_FLAG_RANGE] = (a.acc[7] != sub_opnd[7]) &&
                                            (diff[7] != a.acc[7]);
            if (a.op == OP_MINUS_TO_MEMORY) begin
               a.res_mem = diff[7:0];
               a.mem_we  = 1'b1;
            end else begin
               a.res_acc = diff[7:0];
               a.acc_we  = 1'b1;
            end
         end
         OP_NIBBLE_EXCHANGE_MEM: begin
            a.res_mem = {a.mem[3:0], a.mem[7:4]};
            a.mem_we  = 1'b1;
         end
         OP_NIBBLE_EXCHANGE_TO_WORK: begin
            a.res_acc = {a.mem[3:0], a.mem[7:4]};
            a.acc_we  = 1'b1;
         end
         OP_SKIP_WHEN_NULL: begin
            a.skip = (a.mem == 8'h00);
         end
         OP_LOAD_THEN_SKIP_NULL: begin
            a.res_acc = a.mem;
            a.acc_we  = 1'b1;
            a.skip    = (a.mem == 8'h00);
         end
         default: begin
            a.skip = 1'b0;
         end
      endcase
   end

endmodule

// ---- rtl/sspe_alu_if.sv ----
// operands and results between the sequencer and the datapath
`timescale 1ns/1ps
interface sspe_alu_if;
   import sspe_pkg::*;
   sspe_op_e    op;
   logic [7:0]  acc;
   logic [7:0]  mem;
   logic [7:0]  imm;
   logic [2:0]  bit_sel;
   sspe_flags_t flags;
   logic [7:0]  res_acc;
   logic [7:0]  res_mem;
   sspe_flags_t res_flags;
   logic        acc_we;
   logic        mem_we;
   logic        skip;

   modport alu  (input  op, acc, mem, imm, bit_sel, flags,
                 output res_acc, res_mem, res_flags, acc_we, mem_we, skip);
   modport core (output op, acc, mem, imm, bit_sel, flags,
                 input  res_acc, res_mem, res_flags, acc_we, mem_we, skip);
endinterface

// ---- rtl/sspe_pkg.sv ----
// types shared by the execution block
package sspe_pkg;

   typedef enum logic [3:0] {
      OP_DECR_TO_WORK_SKIP      = 4'h0,
      OP_FILL_BYTE              = 4'h1,
      OP_FILL_BIT               = 4'h2,
      OP_INCR_SKIP_MEM          = 4'h3,
      OP_INCR_TO_WORK_SKIP      = 4'h4,
      OP_SKIP_WHEN_BIT_HIGH     = 4'h5,
      OP_MINUS_TO_WORK          = 4'h6,
      OP_MINUS_TO_MEMORY        = 4'h7,
      OP_MINUS_IMM              = 4'h8,
      OP_NIBBLE_EXCHANGE_MEM    = 4'h9,
      OP_NIBBLE_EXCHANGE_TO_WORK = 4'ha,
      OP_SKIP_WHEN_NULL         = 4'hb,
      OP_LOAD_THEN_SKIP_NULL    = 4'hc,
      OP_SKIP_WHEN_BIT_LOW      = 4'hd
   } sspe_op_e;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_EXEC  = 3'b010,
      ST_DUMMY = 3'b100
   } sspe_state_e;

   typedef logic [3:0] sspe_flags_t;

endpackage

// ---- rtl/sspe_regs.svh ----
// register offsets, field positions and reset values of the execution block
`ifndef SSPE_REGS_SVH
`define SSPE_REGS_SVH

// -----------------------------------------------------------------------------
// byte offsets on the register bus
// -----------------------------------------------------------------------------
`define SSPE_OFF_INSTR    8'h00
`define SSPE_OFF_ACC      8'h04
`define SSPE_OFF_FLAGS    8'h08
`define SSPE_OFF_STATUS   8'h0c
`define SSPE_OFF_MEM_ADDR 8'h10
`define SSPE_OFF_MEM_DATA 8'h14

// -----------------------------------------------------------------------------
// instruction register fields
// -----------------------------------------------------------------------------
`define SSPE_INSTR_OP_LSB   0
`define SSPE_INSTR_OP_MSB   3
`define SSPE_INSTR_BIT_LSB  4
`define SSPE_INSTR_BIT_MSB  6
`define SSPE_INSTR_ADR_LSB  8
`define SSPE_INSTR_ADR_MSB  15
`define SSPE_INSTR_IMM_LSB  16
`define SSPE_INSTR_IMM_MSB  23
`define SSPE_INSTR_WIDTH    24

// -----------------------------------------------------------------------------
// flag register bits
// -----------------------------------------------------------------------------
`define SSPE_FLAG_CARRY     0
`define SSPE_FLAG_HALF      1
`define SSPE_FLAG_ZERO      2
`define SSPE_FLAG_RANGE     3

// -----------------------------------------------------------------------------
// status register bits
// -----------------------------------------------------------------------------
`define SSPE_STAT_BUSY      0
`define SSPE_STAT_SKIP      1
`define SSPE_STAT_CNT_LSB   8
`define SSPE_STAT_CNT_MSB   15

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define SSPE_RST_INSTR      24'h000000
`define SSPE_RST_ACC        8'h00
`define SSPE_RST_FLAGS      4'h0
`define SSPE_RST_MEM_ADDR   8'h00
`define SSPE_RST_SKIP_CNT   8'h00

`endif

// ---- rtl/sspe_top.sv ----
// execution block for skip, fill, subtract and swap instructions
`timescale 1ns/1ps
`include "sspe_regs.svh"
module sspe_top #(
   parameter int DEPTH = 256   // data memory bytes
) (
   input  wire logic        CLOCK_I,     // 100 MHz clock
   input  wire logic        RST_N_I,     // async reset, active low
   input  wire logic        CYC_I,       // wishbone cycle
   input  wire logic        STB_I,       // wishbone strobe
   input  wire logic        WE_I,        // wishbone write enable
   input  wire logic [7:0]  ADR_I,       // wishbone byte address
   input  wire logic [3:0]  SEL_I,       // wishbone byte lanes
   input  wire logic [31:0] DAT_I,       // wishbone write data
   output      logic [31:0] DAT_O,       // wishbone read data
   output      logic        ACK_O,       // wishbone acknowledge
   output      logic        BUSY_O,      // instruction in progress
   output      logic        SKIP_O       // prefetch discarded, dummy cycle
);
   import sspe_pkg::*;

   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || DEPTH > 256)
         $error("sspe_top: DEPTH must be 2 to 256");
   end

   // -----------------------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // -----------------------------------------------------------------------------
   // state
   // -----------------------------------------------------------------------------
   logic [`SSPE_INSTR_WIDTH-1:0] instr_reg,    instr_next;
   logic [7:0]                   acc_reg,      acc_next;
   sspe_flags_t                  flags_reg,    flags_next;
   logic [7:0]                   mem_addr_reg, mem_addr_next;
   logic [7:0]                   skip_cnt_reg, skip_cnt_next;
   logic                         last_skip_reg, last_skip_next;
   sspe_state_e                  state_reg,    state_next;
   logic                         ack_reg,      ack_next;
   logic [31:0]                  dat_reg,      dat_next;
   logic [7:0]                   mem [DEPTH];
   logic                         mem_we;
   logic [AW-1:0]                mem_wa;
   logic [7:0]                   mem_wd;

   sspe_alu_if alu_bus ();

   sspe_alu sspe_alu_inst (
      .a (alu_bus.alu)
   );

   // -----------------------------------------------------------------------------
   // datapath operands
   // -----------------------------------------------------------------------------
   logic [7:0] op_addr;
   logic [7:0] win_data;

   assign op_addr = instr_reg[`SSPE_INSTR_ADR_MSB:`SSPE_INSTR_ADR_LSB];
   assign win_data = mem[mem_addr_reg[AW-1:0]];

   assign alu_bus.op      = sspe_op_e'(
                            instr_reg[`SSPE_INSTR_OP_MSB:`SSPE_INSTR_OP_LSB]);
   assign alu_bus.acc     = acc_reg;
   assign alu_bus.mem     = mem[op_addr[AW-1:0]];
   assign alu_bus.imm     = instr_reg[`SSPE_INSTR_IMM_MSB:`SSPE_INSTR_IMM_LSB];
   assign alu_bus.bit_sel = instr_reg[`SSPE_INSTR_BIT_MSB:`SSPE_INSTR_BIT_LSB];
   assign alu_bus.flags   = flags_reg;

   // -----------------------------------------------------------------------------
   // bus decode helpers
   // -----------------------------------------------------------------------------
   logic bus_req;
   logic bus_wr;
   logic idle;

   assign bus_req = CYC_I & STB_I & ~ack_reg;
   assign bus_wr  = bus_req & WE_I;
   assign idle    = (state_reg == ST_IDLE);

   function automatic logic [7:0] lane0(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
      lane0 = s[0] ? d[7:0] : old;
   endfunction

   // -----------------------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------------------
   always_comb begin
      instr_next     = instr_reg;
      acc_next       = acc_reg;
      flags_next     = flags_reg;
      mem_addr_next  = mem_addr_reg;
      skip_cnt_next  = skip_cnt_reg;
      last_skip_next = last_skip_reg;
      state_next     = state_reg;
      ack_next       = bus_req;
      dat_next       = dat_reg;
      mem_we         = 1'b0;
      mem_wa         = mem_addr_reg[AW-1:0];
      mem_wd         = 8'h00;

      // sequencer
      unique case (state_reg)
         ST_IDLE: begin
            if (bus_wr && ADR_I == `SSPE_OFF_INSTR)
               state_next = ST_EXEC;
         end
         ST_EXEC: begin
            if (alu_bus.acc_we)
               acc_next = alu_bus.res_acc;
            flags_next = alu_bus.res_flags;
            if (alu_bus.mem_we) begin
               mem_we = 1'b1;
               mem_wa = op_addr[AW-1:0];
               mem_wd = alu_bus.res_mem;
            end
            last_skip_next = alu_bus.skip;
            if (alu_bus.skip) begin
               state_next    = ST_DUMMY;
               skip_cnt_next = skip_cnt_reg + 8'h01;
            end else begin
               state_next = ST_IDLE;
            end
         end
         ST_DUMMY: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase

      // register writes, refused while an instruction runs
      if (bus_wr && idle) begin
         unique case (ADR_I)
            `SSPE_OFF_INSTR: begin
               if (SEL_I[0]) instr_next[7:0]   = DAT_I[7:0];
               if (SEL_I[1]) instr_next[15:8]  = DAT_I[15:8];
               if (SEL_I[2]) instr_next[23:16] = DAT_I[23:16];
            end
            `SSPE_OFF_ACC:      acc_next      = lane0(acc_reg, DAT_I, SEL_I);
            `SSPE_OFF_FLAGS: begin
               if (SEL_I[0]) flags_next = DAT_I[3:0];
            end
            `SSPE_OFF_MEM_ADDR: mem_addr_next = lane0(mem_addr_reg, DAT_I,
                                                      SEL_I);
            `SSPE_OFF_MEM_DATA: begin
               mem_we = SEL_I[0];
               mem_wd = DAT_I[7:0];
            end
            default: begin
               mem_we = 1'b0;
            end
         endcase
      end

      // register reads
      if (bus_req && !WE_I) begin
         unique case (ADR_I)
            `SSPE_OFF_INSTR:    dat_next = {8'h00, instr_reg};
            `SSPE_OFF_ACC:      dat_next = {24'h000000, acc_reg};
            `SSPE_OFF_FLAGS:    dat_next = {28'h0000000, flags_reg};
            `SSPE_OFF_STATUS:   dat_next = {16'h0000, skip_cnt_reg, 6'h00,
                                            last_skip_reg, ~idle};
            `SSPE_OFF_MEM_ADDR: dat_next = {24'h000000, mem_addr_reg};
            `SSPE_OFF_MEM_DATA: dat_next = {24'h000000, win_data};
            default:            dat_next = 32'h00000000;
         endcase
      end else if (bus_req) begin
         dat_next = 32'h00000000;
      end
   end

   // -----------------------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------------------
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         instr_reg     <= `SSPE_RST_INSTR;
         acc_reg       <= `SSPE_RST_ACC;
         flags_reg     <= `SSPE_RST_FLAGS;
         mem_addr_reg  <= `SSPE_RST_MEM_ADDR;
         skip_cnt_reg  <= `SSPE_RST_SKIP_CNT;
         last_skip_reg <= 1'b0;
         state_reg     <= ST_IDLE;
         ack_reg       <= 1'b0;
         dat_reg       <= 32'h00000000;
      end else begin
         instr_reg     <= instr_next;
         acc_reg       <= acc_next;
         flags_reg     <= flags_next;
         mem_addr_reg  <= mem_addr_next;
         skip_cnt_reg  <= skip_cnt_next;
         last_skip_reg <= last_skip_next;
         state_reg     <= state_next;
         ack_reg       <= ack_next;
         dat_reg       <= dat_next;
      end
   end

   // data memory, not reset
   always_ff @(posedge CLOCK_I) begin
      if (mem_we)
         mem[mem_wa] <= mem_wd;
   end

   // -----------------------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------------------
   assign DAT_O  = dat_reg;
   assign ACK_O  = ack_reg;
   assign BUSY_O = ~state_reg[0];
   assign SKIP_O = state_reg[2];

endmodule

// ---- verification/sspe_top_sva.sv ----
// bus and sequencing checks on the ports of the execution block
`timescale 1ns/1ps
module sspe_top_sva (
   input wire logic        CLOCK_I,  // clock
   input wire logic        RST_N_I,  // async reset, active low
   input wire logic        CYC_I,    // wishbone cycle
   input wire logic        STB_I,    // wishbone strobe
   input wire logic        WE_I,     // wishbone write enable
   input wire logic [7:0]  ADR_I,    // wishbone address
   input wire logic [31:0] DAT_O,    // read data
   input wire logic        ACK_O,    // acknowledge
   input wire logic        BUSY_O,   // instruction in progress
   input wire logic        SKIP_O    // dummy cycle
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   a_ack_next_cycle: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("request not acked in next cycle");
   a_ack_one_pulse: assert property (ACK_O |=> !ACK_O)
      else $error("ack held longer than one cycle");
   a_ack_has_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
      else $error("ack without request");
   a_write_reads_zero: assert property (ACK_O && $past(WE_I) |-> DAT_O == 0)
      else $error("read data not zero on write ack");
   a_start_on_instr: assert property ($rose(BUSY_O) |->
      $past(CYC_I && STB_I && WE_I && !ACK_O && ADR_I == 8'h00))
      else $error("execution began without an instruction write");
   a_exec_length: assert property ($rose(BUSY_O) |-> ##[1:2] !BUSY_O)
      else $error("instruction longer than two cycles");
   a_skip_in_busy: assert property (SKIP_O |-> BUSY_O)
      else $error("dummy cycle outside instruction");
   a_skip_one_dummy: assert property (SKIP_O |=> !SKIP_O && !BUSY_O)
      else $error("dummy cycle not single");
   a_skip_after_exec: assert property ($rose(SKIP_O) |->
      $past(BUSY_O) && !$past(SKIP_O))
      else $error("dummy cycle not after execute cycle");
endmodule

bind sspe_top sspe_top_sva sspe_top_sva_inst (
   .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CYC_I(CYC_I), .STB_I(STB_I),
   .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
   .BUSY_O(BUSY_O), .SKIP_O(SKIP_O));

// ---- verification/sspe_top_tb.sv ----
// self-checking testbench of the execution block
`timescale 1ns/1ps
`include "sspe_regs.svh"
module sspe_top_tb;
   import sspe_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc, stb, we, ack, busy, skip, tmo;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   int          miscompares = 0;
   int          n_checks = 0;
   logic [7:0]  n_skips = 8'h00;

   always #5 clk = ~clk;

   sspe_top sspe_top_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc),
      .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
      .DAT_O(rdat), .ACK_O(ack), .BUSY_O(busy), .SKIP_O(skip));
   sspe_wbm sspe_wbm_inst (.clk_i(clk), .dat_i(rdat), .ack_i(ack),
      .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wdat), .tmo_o(tmo));

   task automatic chk(input logic ok, input string s);
      n_checks++;
      if (!ok) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      sspe_wbm_inst.xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      sspe_wbm_inst.xfer(1'b0, a, 32'h0, q);
      chk(q === e, "read data");
   endtask

   // -------------------------------------------------------------------
   // runs one instruction at address 05 with flags preset to a
   // -------------------------------------------------------------------
   task automatic exe(input logic [3:0] op, input logic [2:0] bi,
      input logic [7:0] m, a, im, em, ea, input logic es,
      input logic [3:0] ef);
      wr(`SSPE_OFF_MEM_DATA, {24'h0, m});
      wr(`SSPE_OFF_ACC, {24'h0, a});
      wr(`SSPE_OFF_FLAGS, 32'ha);
      wr(`SSPE_OFF_INSTR, {8'h0, im, 8'h05, 1'b0, bi, op});
      chk(busy === es && skip === es, "dummy cycle");
      @(posedge clk);
      chk(busy === 1'b0, "instruction length");
      rd(`SSPE_OFF_ACC, {24'h0, ea});
      rd(`SSPE_OFF_FLAGS, {28'h0, ef});
      rd(`SSPE_OFF_MEM_DATA, {24'h0, em});
      if (es) n_skips = n_skips + 8'h01;
      rd(`SSPE_OFF_STATUS, {16'h0, n_skips, 6'h0, es, 1'b0});
   endtask

   function automatic logic [11:0] sbf(input logic [7:0] a, b);
      logic [8:0] r;
      logic [4:0] h;
      r = {1'b0, a} + {1'b0, ~b} + 9'h1;
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h1;
      return {(a[7] != b[7]) && (r[7] != a[7]), r[7:0] == 8'h0, h[4],
              r[8], r[7:0]};
   endfunction

   task automatic t_reset();
      logic [7:0] o[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
      // data memory is not reset: give byte 0 a known value first
      wr(`SSPE_OFF_MEM_DATA, 32'h0);
      foreach (o[i]) rd(o[i], 32'h0);
      rd(`SSPE_OFF_MEM_DATA, 32'h0);
      wr(`SSPE_OFF_MEM_ADDR, 32'h5);
   endtask

   task automatic t_incdec();
      exe(OP_DECR_TO_WORK_SKIP, 0, 8'h01, 8'h33, 0, 8'h01, 0, 1, 4'ha);
      exe(OP_DECR_TO_WORK_SKIP, 0, 0, 8'h33, 0, 0, 8'hff, 0, 4'ha);
      exe(OP_INCR_SKIP_MEM, 0, 8'hff, 8'h33, 0, 0, 8'h33, 1, 4'ha);
      exe(OP_INCR_SKIP_MEM, 0, 8'h7f, 8'h33, 0, 8'h80, 8'h33, 0, 4'ha);
      exe(OP_INCR_TO_WORK_SKIP, 0, 8'hff, 8'h33, 0, 8'hff, 0, 1, 4'ha);
      exe(OP_INCR_TO_WORK_SKIP, 0, 8'h41, 0, 0, 8'h41, 8'h42, 0, 4'ha);
   endtask

   task automatic t_bits();
      logic [7:0] b;
      exe(OP_FILL_BYTE, 0, 8'h3c, 8'h33, 0, 8'hff, 8'h33, 0, 4'ha);
      for (int i = 0; i < 8; i++) begin
         b = 8'h01 << i;
         exe(OP_FILL_BIT, i[2:0], 0, 8'h33, 0, b, 8'h33, 0, 4'ha);
         exe(OP_FILL_BIT, i[2:0], ~b, 0, 0, 8'hff, 0, 0, 4'ha);
         exe(OP_SKIP_WHEN_BIT_HIGH, i[2:0], b, 0, 0, b, 0, 1, 4'ha);
         exe(OP_SKIP_WHEN_BIT_HIGH, i[2:0], ~b, 0, 0, ~b, 0, 0, 4'ha);
         exe(OP_SKIP_WHEN_BIT_LOW, i[2:0], ~b, 0, 0, ~b, 0, 1, 4'ha);
         exe(OP_SKIP_WHEN_BIT_LOW, i[2:0], b, 0, 0, b, 0, 0, 4'ha);
      end
   endtask

   task automatic t_sub();
      logic [7:0] a[4] = '{8'h10, 8'h80, 8'h00, 8'h37};
      logic [7:0] b[4] = '{8'h01, 8'h01, 8'h01, 8'h37};
      logic [11:0] e;
      foreach (a[i]) begin
         e = sbf(a[i], b[i]);
         exe(OP_MINUS_TO_WORK, 0, b[i], a[i], 0, b[i], e[7:0], 0,
             e[11:8]);
         exe(OP_MINUS_TO_MEMORY, 0, b[i], a[i], 0, e[7:0], a[i], 0,
             e[11:8]);
         exe(OP_MINUS_IMM, 0, 8'h5a, a[i], b[i], 8'h5a, e[7:0], 0,
             e[11:8]);
      end
   endtask

   task automatic t_swap_zero();
      exe(OP_NIBBLE_EXCHANGE_MEM, 0, 8'ha5, 0, 0, 8'h5a, 0, 0, 4'ha);
      exe(OP_NIBBLE_EXCHANGE_TO_WORK, 0, 8'h3c, 0, 0, 8'h3c, 8'hc3, 0,
          4'ha);
      exe(OP_SKIP_WHEN_NULL, 0, 0, 8'h33, 0, 0, 8'h33, 1, 4'ha);
      exe(OP_SKIP_WHEN_NULL, 0, 8'h80, 8'h33, 0, 8'h80, 8'h33, 0, 4'ha);
      exe(OP_LOAD_THEN_SKIP_NULL, 0, 0, 8'h33, 0, 0, 0, 1, 4'ha);
      exe(OP_LOAD_THEN_SKIP_NULL, 0, 8'h42, 0, 0, 8'h42, 8'h42, 0, 4'ha);
   endtask

   task automatic end_of_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // 73 instructions of some 25 cycles each fit well inside this
   initial begin
      #200us;
      miscompares++;
      end_of_test();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_incdec();
      t_bits();
      t_sub();
      t_swap_zero();
      chk(tmo === 1'b0, "bus answer missing");
      end_of_test();
   end
endmodule

// ---- verification/sspe_wbm.sv ----
// classic wishbone master model that reaches the execution block's registers
`timescale 1ns/1ps
module sspe_wbm (
   input  wire logic        clk_i,  // bus clock
   input  wire logic [31:0] dat_i,  // read data from slave
   input  wire logic        ack_i,  // slave acknowledge
   output      logic        cyc_o,  // cycle
   output      logic        stb_o,  // strobe
   output      logic        we_o,   // write enable
   output      logic [7:0]  adr_o,  // byte address
   output      logic [3:0]  sel_o,  // byte lanes
   output      logic [31:0] dat_o,  // write data
   output      logic        tmo_o   // an answer never came
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'hf;
      dat_o = 32'h0;
      tmo_o = 1'b0;
   end

   // -------------------------------------------------------------------
   // one single cycle; entered just after a rising edge
   // -------------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      dat_o <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 16);
      if (ack_i !== 1'b1) tmo_o <= 1'b1;
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // keeps the bus idle for one cycle between requests
      @(posedge clk_i);
   endtask
endmodule
